// >>> bench/dual_bus_synth_control_port_tb.sv
// Purpose: Self-checking bench for the synthesizer serial control port
// Assumes: Host model drives serial pins; straps and lock driven here
// Notes:   Driver queues expected state, a watcher compares it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module dual_bus_synth_control_port_tb;
  import synth_port_pkg::*;
  typedef struct packed {
    logic [DIV_W-1:0]  dv;
    logic [BAND_W-1:0] bd;
    logic              cp;
    logic [TEST_W-1:0] t;
    logic              ra;
    logic              rb;
    logic              os;
  } note_t;
  localparam note_t RST = '{dv: DIV_RESET, bd: BAND_RESET, cp: CP_RESET, t: TEST_NORMAL,
                            ra: RSA_RESET, rb: 1'h0, os: OS_RESET};
  logic              core_clk_i, rstn_i, fmt, s_hi, s_lo, locked;
  wire logic         scl, sda_low, enable, sda_line;
  logic              sda_oe, cp, rsa, ratio_sel_b, os, ten, poff, psink, psrc, lock;
  logic [DIV_W-1:0]  div;
  logic [BAND_W-1:0] band;
  logic [TEST_W-1:0] test;
  logic [REF_W-1:0]  refd;
  logic [31:0]       seed = 32'hac9a36c6;
  logic [1:0]        bands [3] = '{2'h0, 2'h2, 2'h3};
  note_t             e;
  note_t             notes[$];
  event              obs_ev;
  int                miscompares = 0;
  int                tests_run = 0;
  int                cycles = 0;
  assign sda_line = ~(sda_low | sda_oe);
  host_bus_model host (.clk_i(core_clk_i), .sda_line_i(sda_line), .scl_o(scl),
    .sda_low_o(sda_low), .enable_o(enable));
  synth_ctl_port #(.RSB_RESET(1'h0), .CTL27_LSB(0)) uut (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .bus_format_strap_i(fmt), .addr_strap_hi_i(s_hi),
    .addr_strap_lo_i(s_lo), .enable_i(enable), .scl_i(scl), .sda_i(sda_line),
    .loop_locked_i(locked), .ref_clk_i(locked), .div_half_i(~locked), .sda_o(),
    .sda_oe_o(sda_oe), .divider_word_o(div), .band_buffer_ctl_o(band),
    .pump_current_sel_o(cp), .test_mode_bits_o(test), .ratio_sel_a_o(rsa),
    .ratio_sel_b_o(ratio_sel_b), .tune_output_off_o(os), .tune_output_en_o(ten),
    .ref_divider_o(refd), .pump_off_o(poff), .pump_sink_o(psink),
    .pump_source_o(psrc), .lock_o(lock));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] rand_word();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Long settle covers pin synchronisers plus decode lag
  task automatic push();
    logic [31:0] t;
    t = rand_word();
    locked = t[0];
    notes.push_back(e);
    repeat (10) @(negedge core_clk_i);
    -> obs_ev;
  endtask
  task automatic set_ctl(input logic [7:0] c);
    e.cp = c[CB_CP];
    e.t = c[CB_T_HI:CB_T_LO];
    e.ra = c[CB_RSA];
    e.rb = c[CB_RSB];
    e.os = c[CB_OS];
  endtask
  task automatic i2c_xfer(input logic [7:0] adr, input logic [7:0] q[$], input logic ak);
    logic a;
    host.start_cond();
    host.send_byte(adr, a);
    `CHK(a, ak)
    foreach (q[i]) begin
      host.send_byte(q[i], a);
      `CHK(a, ak)
    end
    host.stop_cond();
  endtask
  // --------------------------------------------------------------
  // Watcher, timeout and clock
  // --------------------------------------------------------------
  initial forever begin
    note_t n;
    @(obs_ev);
    n = notes.pop_front();
    `CHK({div, band, cp, test, rsa, ratio_sel_b, os}, n)
    `CHK(ten, ~n.os)
    `CHK(refd, !n.rb ? REF_640 : (n.ra ? REF_512 : REF_1024))
    `CHK({poff, psink, psrc}, {n.t[2:1] == 2'h1, n.t == TEST_SINK, n.t == TEST_SOURCE})
    if (n.t == TEST_NORMAL) `CHK(lock, ~locked)
    if (n.t == TEST_REF) `CHK(lock, locked)
    if (n.t == TEST_DIVH) `CHK(lock, ~locked)
  end
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0]  c;
    {fmt, s_hi, s_lo, locked, rstn_i} = 5'h00;
    e = RST;
    repeat (16) @(negedge core_clk_i);
    rstn_i = 1'b1;
    push();
    foreach (bands[i]) begin
      {s_hi, s_lo} = bands[i];
      r = rand_word();
      e.dv = r[14:0];
      i2c_xfer({ADDR_FIXED, bands[i], 1'b0}, '{{1'b0, r[14:8]}, r[7:0]}, 1'b1);
      push();
    end
    i2c_xfer(8'hc4, '{8'h00, 8'h55}, 1'b0);
    push();
    r = rand_word();
    c = {1'b1, r[22:16]};
    i2c_xfer(8'hc2, '{{1'b0, r[14:8]}, r[7:0], c, r[31:24], 8'h5a, 8'h3c}, 1'b1);
    set_ctl(c);
    e.bd = r[27:24];
    e.dv = 15'h5a3c;
    push();
    for (int i = 0; i < 8; i++) begin
      c = {1'b1, i[0], i[2:0], i[1:0], i[2]};
      r = rand_word();
      i2c_xfer(8'hc2, '{c, r[7:0]}, 1'b1);
      set_ctl(c);
      e.bd = r[3:0];
      push();
    end
    fmt = 1'b1;
    r = rand_word();
    host.tw_word({r[31:28], r[26:12], r[7:0]}, 27);
    {e.bd, e.dv} = {r[31:28], r[26:12]};
    set_ctl(r[7:0]);
    push();
    r = rand_word();
    host.tw_word({8'h00, r[18:0]}, 19);
    {e.bd, e.dv, e.ra} = {r[18:0], 1'b0};
    push();
    r = rand_word();
    host.tw_word({9'h000, r[17:0]}, 18);
    {e.bd, e.dv, e.ra} = {r[17:14], 1'b0, r[13:0], 1'b1};
    push();
    r = rand_word();
    host.tw_word({17'h00000, r[9:0]}, 10);
    e.bd = r[9:6];
    push();
    rstn_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    rstn_i = 1'b1;
    e = RST;
    push();
    // Let the watcher finish the last note first
    repeat (2) @(negedge core_clk_i);
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> bench/host_bus_model.sv
// Purpose: Host controller model driving the serial control pins
// Assumes: Open-drain data line resolved by the bench with a pull-up
// Notes:   Each phase lasts HALF core cycles, above the 4-cycle minimum
`timescale 1ns/1ps
`default_nettype none
module host_bus_model #(
  parameter int HALF = 6
) (
  input  wire logic clk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_low_o,
  output logic      enable_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    enable_o = 1'b0;
  end
  task automatic gap();
    repeat (HALF) @(negedge clk_i);
  endtask
  // Data moves only while the clock is low, so no false start or stop
  task automatic clk_bit(input logic b);
    sda_low_o = ~b;
    gap();
    scl_o = 1'b1;
    gap();
    scl_o = 1'b0;
    gap();
  endtask
  task automatic start_cond();
    sda_low_o = 1'b1;
    gap();
    scl_o = 1'b0;
    gap();
  endtask
  task automatic stop_cond();
    sda_low_o = 1'b1;
    gap();
    scl_o = 1'b1;
    gap();
    sda_low_o = 1'b0;
    gap();
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(b[i]);
    sda_low_o = 1'b0;
    gap();
    scl_o = 1'b1;
    gap();
    ack = ~sda_line_i;
    scl_o = 1'b0;
    gap();
  endtask
  // Clock parks low between words; data released after each word
  task automatic tw_word(input logic [26:0] w, input int n);
    scl_o = 1'b0;
    gap();
    enable_o = 1'b1;
    gap();
    for (int i = n - 1; i >= 0; i--) clk_bit(w[i]);
    enable_o = 1'b0;
    sda_low_o = 1'b0;
    gap();
  endtask
endmodule
`default_nettype wire

// >>> core/synth_ctl_port.sv
// Purpose: Serial control front end of a bus-programmed synthesizer
// Assumes: Address strap band already digitised; open strap pulled high
// Notes:   All pins pass a two-flop synchroniser before use
// Functional notes
// - Strap high or open selects three-wire port; low selects two-wire bus.
// - Two-wire address 11000, two strap bits, write 0; acknowledge address and data.
// - Strap bits from select pin band; pattern 01 always accepted.
// - Data bytes follow address with automatic advance; four bytes program everything.
// - Leading 0 starts divider byte pair; leading 1 starts control then band byte.
// - Further data bytes keep being routed until a stop condition.
// - Divider, control and band registers load after eighth clock of their byte.
// - Divider is binary: upper byte holds bits 14..8, lower byte bits 7..0.
// - Control byte carries pump current, test bits, ratio selects, tuning off.
// - Tuning output enabled when tuning-off bit is 0, high impedance when 1.
// - Low four band bits switch buffers; upper four bits ignored.
// - Test bits select normal, pump off, sink, source, or lock pin routing.
// - Ratio select B low gives 640; else A low 1024, A high 512.
// - Three-wire data shifts in on falling clock edges while enable high.
// - First four three-wire bits load band register on fifth rising edge.
// - Eighteen or nineteen bit words load divider when enable falls.
// - Eighteen bits clear divider bit 14, set A; nineteen bits clear A.
// - Twenty-seven bit word loads divider at edge 20, control at enable fall.
// - Other control bits change only on twenty-seven bit words.
// - Words shorter than eighteen bits leave the divider unchanged.
// - Reset: 280 uA pump, tuning off, normal test, variant B value.
// - Second variant starts at reference ratio 1024.
// - Outside lock test routing, lock pin low when locked, high otherwise.
`timescale 1ns/1ps
`default_nettype none
module synth_ctl_port
  import synth_port_pkg::*;
#(
  parameter logic RSB_RESET   = 1'h0,
  parameter int   CTL27_LSB   = 0
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              rstn_i,
  input  wire logic                              bus_format_strap_i,
  input  wire logic                              addr_strap_hi_i,
  input  wire logic                              addr_strap_lo_i,
  input  wire logic                              enable_i,
  input  wire logic                              scl_i,
  input  wire logic                              sda_i,
  input  wire logic                              loop_locked_i,
  input  wire logic                              ref_clk_i,
  input  wire logic                              div_half_i,
  output logic                                   sda_o,
  output logic                                   sda_oe_o,
  output logic [synth_port_pkg::DIV_W-1:0]       divider_word_o,
  output logic [synth_port_pkg::BAND_W-1:0]      band_buffer_ctl_o,
  output logic                                   pump_current_sel_o,
  output logic [synth_port_pkg::TEST_W-1:0]      test_mode_bits_o,
  output logic                                   ratio_sel_a_o,
  output logic                                   ratio_sel_b_o,
  output logic                                   tune_output_off_o,
  output logic                                   tune_output_en_o,
  output logic [synth_port_pkg::REF_W-1:0]       ref_divider_o,
  output logic                                   pump_off_o,
  output logic                                   pump_sink_o,
  output logic                                   pump_source_o,
  output logic                                   lock_o
);
  import synth_port_pkg::*;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic             scl_p;
  logic             sda_p;
  logic             en_p;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {bus_format_strap_i, addr_strap_hi_i, addr_strap_lo_i, enable_i,
                scl_i, sda_i, loop_locked_i, ref_clk_i, div_half_i, 1'h0};
      sync2 <= sync1;
    end
  end

  logic strap_s, ahi_s, alo_s, en_s, scl_s, sda_s, lkd_s, fref_s, fdiv_s;
  assign {strap_s, ahi_s, alo_s, en_s, scl_s, sda_s, lkd_s, fref_s, fdiv_s} =
         sync2[NSYNC-1:1];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_p <= 1'h0;
      sda_p <= 1'h0;
      en_p  <= 1'h0;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      en_p  <= en_s;
    end
  end

  // Open strap is pulled high outside, so it reads as three-wire
  logic mode3, mode2;
  assign mode3 = strap_s;
  assign mode2 = !strap_s;

  logic scl_rise, scl_fall, start_c, stop_c, en_fall;
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  assign start_c  = mode2 && scl_s && scl_p && sda_p && !sda_s;
  assign stop_c   = mode2 && scl_s && scl_p && !sda_p && sda_s;
  assign en_fall  = mode3 && en_p && !en_s;

  // --------------------------------------------------------------
  // Two-wire target
  // --------------------------------------------------------------
  i2c_state_t       i2c_state;
  expect_t          expect_q;
  logic [3:0]       bit_cnt;
  logic [7:0]       byte_sh;
  logic [UPPER_MSB:0] upper_hold;
  logic             ack_on;
  logic             byte_end;
  logic             addr_hit;

  assign byte_end = mode2 && scl_fall && (bit_cnt == BYTE_BITS);
  assign addr_hit = (byte_sh[7:3] == ADDR_FIXED) && !byte_sh[0] &&
                    ((byte_sh[2:1] == {ahi_s, alo_s}) ||
                     (byte_sh[2:1] == ADDR_ALWAYS));

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      i2c_state <= I_IDLE;
      bit_cnt   <= '0;
      byte_sh   <= '0;
      ack_on    <= 1'h0;
    end else if (!mode2 || stop_c) begin
      i2c_state <= I_IDLE;
      bit_cnt   <= '0;
      ack_on    <= 1'h0;
    end else if (start_c) begin
      i2c_state <= I_ADDR;
      bit_cnt   <= '0;
      ack_on    <= 1'h0;
    end else if (i2c_state != I_IDLE) begin
      if (scl_rise && bit_cnt < BYTE_BITS) begin
        byte_sh <= {byte_sh[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (byte_end) begin
        bit_cnt <= ACK_SLOT;
        unique case (i2c_state)
          I_ADDR: begin
            i2c_state <= addr_hit ? I_DATA : I_SKIP;
            ack_on    <= addr_hit;
          end
          I_DATA: ack_on <= 1'h1;
          default: ack_on <= 1'h0;
        endcase
      end else if (scl_fall && bit_cnt == ACK_SLOT) begin
        ack_on  <= 1'h0;
        bit_cnt <= '0;
      end
    end
  end

  assign sda_o    = 1'h0;
  assign sda_oe_o = ack_on;

  // Byte routing by leading bit
  logic i2c_data;
  logic i2c_ld_div, i2c_ld_ctl, i2c_ld_band;
  assign i2c_data    = byte_end && (i2c_state == I_DATA);
  assign i2c_ld_div  = i2c_data && (expect_q == EXP_LOWER);
  assign i2c_ld_ctl  = i2c_data && (expect_q == EXP_ANY) && byte_sh[CB_LEAD];
  assign i2c_ld_band = i2c_data && (expect_q == EXP_BAND);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      expect_q   <= EXP_ANY;
      upper_hold <= '0;
    end else if (start_c) begin
      expect_q <= EXP_ANY;
    end else if (i2c_data) begin
      unique case (expect_q)
        EXP_ANY: begin
          if (byte_sh[CB_LEAD]) begin
            expect_q <= EXP_BAND;
          end else begin
            expect_q   <= EXP_LOWER;
            upper_hold <= byte_sh[UPPER_MSB:0];
          end
        end
        default: expect_q <= EXP_ANY;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Three-wire shift port
  // --------------------------------------------------------------
  logic [WORD_W-1:0] word_sh;
  logic [CNT_W-1:0]  fall_cnt;
  logic [CNT_W-1:0]  rise_cnt;
  logic              w_rise, w_fall;
  assign w_rise = mode3 && en_s && scl_rise;
  assign w_fall = mode3 && en_s && scl_fall;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      word_sh  <= '0;
      fall_cnt <= '0;
      rise_cnt <= '0;
    end else if (!mode3 || !en_s) begin
      fall_cnt <= '0;
      rise_cnt <= '0;
    end else begin
      if (w_fall) begin
        word_sh <= {word_sh[WORD_W-2:0], sda_s};
        if (fall_cnt != CNT_MAX) begin
          fall_cnt <= fall_cnt + 5'h01;
        end
      end
      if (w_rise && rise_cnt != CNT_MAX) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end

  logic w_band, w_div20, w_short, w_long, w_full;
  assign w_band  = w_rise && (rise_cnt + 5'h01 == BAND_EDGE);
  assign w_div20 = w_rise && (rise_cnt + 5'h01 == DIV_EDGE);
  assign w_short = en_fall && (fall_cnt == BITS_SHORT);
  assign w_long  = en_fall && (fall_cnt == BITS_LONG);
  assign w_full  = en_fall && (fall_cnt == BITS_FULL);

  // --------------------------------------------------------------
  // Programmed registers
  // --------------------------------------------------------------
  logic [7:0] ctl_src;
  assign ctl_src = i2c_ld_ctl ? byte_sh : word_sh[CTL27_LSB +: 8];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      divider_word_o <= DIV_RESET;
    end else if (i2c_ld_div) begin
      divider_word_o <= {upper_hold, byte_sh};
    end else if (w_div20 || w_long) begin
      divider_word_o <= word_sh[DIV_W-1:0];
    end else if (w_short) begin
      divider_word_o <= {1'h0, word_sh[DIV_W-2:0]};
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      band_buffer_ctl_o <= BAND_RESET;
    end else if (i2c_ld_band) begin
      band_buffer_ctl_o <= byte_sh[BAND_W-1:0];
    end else if (w_band) begin
      band_buffer_ctl_o <= word_sh[BAND_W-1:0];
    end
  end

  // Short words touch only ratio select A
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pump_current_sel_o <= CP_RESET;
      test_mode_bits_o   <= TEST_NORMAL;
      ratio_sel_a_o      <= RSA_RESET;
      ratio_sel_b_o      <= RSB_RESET;
      tune_output_off_o  <= OS_RESET;
    end else if (i2c_ld_ctl || w_full) begin
      pump_current_sel_o <= ctl_src[CB_CP];
      test_mode_bits_o   <= ctl_src[CB_T_HI:CB_T_LO];
      ratio_sel_a_o      <= ctl_src[CB_RSA];
      ratio_sel_b_o      <= ctl_src[CB_RSB];
      tune_output_off_o  <= ctl_src[CB_OS];
    end else if (w_short) begin
      ratio_sel_a_o <= 1'h1;
    end else if (w_long) begin
      ratio_sel_a_o <= 1'h0;
    end
  end

  assign tune_output_en_o = !tune_output_off_o;

  // --------------------------------------------------------------
  // Decoded controls, one cycle behind the settings
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_divider_o <= RSB_RESET ? REF_1024 : REF_640;
      pump_off_o    <= 1'h0;
      pump_sink_o   <= 1'h0;
      pump_source_o <= 1'h0;
      lock_o        <= 1'h1;
    end else begin
      if (!ratio_sel_b_o) begin
        ref_divider_o <= REF_640;
      end else begin
        ref_divider_o <= ratio_sel_a_o ? REF_512 : REF_1024;
      end
      pump_off_o    <= (test_mode_bits_o[2:1] == 2'h1);
      pump_sink_o   <= (test_mode_bits_o == TEST_SINK);
      pump_source_o <= (test_mode_bits_o == TEST_SOURCE);
      if (test_mode_bits_o == TEST_REF) begin
        lock_o <= fref_s;
      end else if (test_mode_bits_o == TEST_DIVH) begin
        lock_o <= fdiv_s;
      end else begin
        lock_o <= !lkd_s;
      end
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  sequence s_enable_drop;
    en_p && !en_s && mode3;
  endsequence

  property p_reset_defaults;
    @(posedge core_clk_i) $rose(rstn_i) |->
      pump_current_sel_o && tune_output_off_o && test_mode_bits_o == TEST_NORMAL;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset defaults");

  property p_ratio;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (!ratio_sel_b_o ##1 1) |-> ref_divider_o == REF_640;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio 640 not applied");

  property p_short_word_keeps;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (s_enable_drop and (fall_cnt < BITS_SHORT)) |=> $stable(divider_word_o);
  endproperty
  a_short_word_keeps: assert property (p_short_word_keeps) else $error("short word moved divider");

  property p_word18;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (s_enable_drop and (fall_cnt == BITS_SHORT)) |=>
        !divider_word_o[DIV_W-1] && ratio_sel_a_o && $stable(ratio_sel_b_o);
  endproperty
  a_word18: assert property (p_word18) else $error("18-bit word handling wrong");

  property p_nack_foreign;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (byte_end && i2c_state == I_ADDR && !addr_hit) |=> !sda_oe_o [*2];
  endproperty
  a_nack_foreign: assert property (p_nack_foreign) else $error("foreign address acknowledged");

  property p_ack_addr;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (byte_end && i2c_state == I_ADDR && addr_hit && !stop_c && !start_c) |=>
        sda_oe_o && !sda_o && i2c_state == I_DATA;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

  property p_band_edge;
    @(posedge core_clk_i) disable iff (!rstn_i)
      w_band |=> band_buffer_ctl_o == $past(word_sh[BAND_W-1:0]);
  endproperty
  a_band_edge: assert property (p_band_edge) else $error("band not loaded at 5th edge");

  property p_lock_normal;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (test_mode_bits_o == TEST_NORMAL) [*2] |-> lock_o == !$past(lkd_s);
  endproperty
  a_lock_normal: assert property (p_lock_normal) else $error("lock pin wrong");

  property p_tune_off;
    @(posedge core_clk_i) disable iff (!rstn_i)
      tune_output_en_o != tune_output_off_o;
  endproperty
  a_tune_off: assert property (p_tune_off) else $error("tuning enable mismatch");
endmodule
`default_nettype wire

// >>> pkg/synth_port_pkg.sv
// Purpose: Shared constants for the synthesizer serial control port
// Assumes: One core clock; serial pins are asynchronous to it
// Notes:   Control byte layout is shared by both bus formats
`default_nettype none
package synth_port_pkg;
  // --------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------
  localparam int DIV_W   = 15;
  localparam int BAND_W  = 4;
  localparam int TEST_W  = 3;
  localparam int REF_W   = 11;
  localparam int WORD_W  = 27;
  localparam int CNT_W   = 5;

  // --------------------------------------------------------------
  // Two-wire address and byte framing
  // --------------------------------------------------------------
  localparam logic [4:0] ADDR_FIXED  = 5'h18;
  localparam logic [1:0] ADDR_ALWAYS = 2'h1;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] ACK_SLOT    = 4'h9;

  // --------------------------------------------------------------
  // Control byte field positions
  // --------------------------------------------------------------
  localparam int CB_LEAD  = 7;
  localparam int CB_CP    = 6;
  localparam int CB_T_HI  = 5;
  localparam int CB_T_LO  = 3;
  localparam int CB_RSA   = 2;
  localparam int CB_RSB   = 1;
  localparam int CB_OS    = 0;
  localparam int UPPER_MSB = 6;

  // --------------------------------------------------------------
  // Three-wire word lengths and load edges
  // --------------------------------------------------------------
  localparam logic [CNT_W-1:0] BITS_SHORT = 5'h12;
  localparam logic [CNT_W-1:0] BITS_LONG  = 5'h13;
  localparam logic [CNT_W-1:0] BITS_FULL  = 5'h1b;
  localparam logic [CNT_W-1:0] BAND_EDGE  = 5'h05;
  localparam logic [CNT_W-1:0] DIV_EDGE   = 5'h14;
  localparam logic [CNT_W-1:0] CNT_MAX    = 5'h1f;

  // --------------------------------------------------------------
  // Test codes, ratios and reset values
  // --------------------------------------------------------------
  localparam logic [TEST_W-1:0] TEST_NORMAL = 3'h1;
  localparam logic [TEST_W-1:0] TEST_SINK   = 3'h6;
  localparam logic [TEST_W-1:0] TEST_SOURCE = 3'h7;
  localparam logic [TEST_W-1:0] TEST_REF    = 3'h4;
  localparam logic [TEST_W-1:0] TEST_DIVH   = 3'h5;
  localparam logic [REF_W-1:0]  REF_640     = 11'h280;
  localparam logic [REF_W-1:0]  REF_1024    = 11'h400;
  localparam logic [REF_W-1:0]  REF_512     = 11'h200;
  localparam logic              CP_RESET    = 1'h1;
  localparam logic              OS_RESET    = 1'h1;
  localparam logic              RSA_RESET   = 1'h0;
  localparam logic [DIV_W-1:0]  DIV_RESET   = 15'h0000;
  localparam logic [BAND_W-1:0] BAND_RESET  = 4'h0;

  typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA, I_SKIP} i2c_state_t;
  typedef enum logic [1:0] {EXP_ANY, EXP_LOWER, EXP_BAND} expect_t;
endpackage
`default_nettype wire
